// >>> inc/ccu_regs.svh
// Register offsets, field positions, reset values and mode codes of the capture/compare unit
`ifndef CCU_REGS_SVH
`define CCU_REGS_SVH
`define CCU_OFF_CTRL1    12'h000
`define CCU_OFF_CTRL2    12'h004
`define CCU_OFF_HOLD1H   12'h008
`define CCU_OFF_HOLD1L   12'h00C
`define CCU_OFF_HOLD2H   12'h010
`define CCU_OFF_HOLD2L   12'h014
`define CCU_OFF_TSEL     12'h018
`define CCU_OFF_ROUTE    12'h01C
`define CCU_OFF_FLAGS    12'h020
`define CCU_OFF_PORT     12'h024
`define CCU_OFF_SLEEP    12'h028
`define CCU_TSEL_U1_BIT  0
`define CCU_TSEL_U2_BIT  3
`define CCU_ROUTE_BIT    0
`define CCU_ROUTE_RST    1'h1
`define CCU_CTRL_RST     8'h00
`define CCU_M_OFF        4'h0
`define CCU_M_TOGGLE     4'h2
`define CCU_M_CAP_FALL   4'h4
`define CCU_M_CAP_RISE   4'h5
`define CCU_M_CAP_R4     4'h6
`define CCU_M_CAP_R16    4'h7
`define CCU_M_SET        4'h8
`define CCU_M_CLR        4'h9
`define CCU_M_SWINT      4'hA
`define CCU_M_SPECIAL    4'hB
`define CCU_PRE4_LAST    4'h3
`define CCU_PRE16_LAST   4'hF
`endif

// >>> inc/ccu_pkg.sv
// Types shared by the capture/compare unit
package ccu_pkg;
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [15:0] hold;
        logic [3:0]  pre;
        logic        flag;
        logic        outl;
        logic        pin_d;
        logic        match_d;
    } ccu_unit_t;
    typedef struct packed {
        ccu_unit_t [1:0] u;
        logic [1:0]      tsel;
        logic            route;
        logic            port_lat;
        logic            port_dir_out;
        logic            sleep;
        logic [31:0]     prdata;
        logic            pready;
        logic            pslverr;
        logic [1:0]      tmr_rst;
        logic [1:0]      tmr_hold;
        logic [2:0]      pin_oe;
        logic [1:0]      pin_o;
    } ccu_state_t;
endpackage

// >>> src/ccu_top.sv
// Two-unit capture/compare block with an APB register port
// Notes on behaviour
// - A port write changing a driven event pin counts as a capture event.
// - Second unit pin route: 0 selects port B pin, 1 (default) port C pin.
// - Changing capture mode may set a spurious flag; allowed.
// - Mode field picks one of four capture prescalings.
// - Prescaler cleared while unit off or not capturing.
// - Every reset clears the prescaler counter.
// - Switching between capture prescalings leaves the counter as is.
// - In sleep a system-clocked timer holds and resumes after wake.
// - Capture still works in sleep with an externally clocked timer.
// - Each unit picks one of two timers through its select bit.
// - Compare mode matches holding pair against selected timer continuously.
// - On match the mode toggles, sets, clears pin, fires special trigger, or interrupts.
// - Compare match sets the flag in the same cycle as the action.
// - Capture copies timer into holding pair and sets a sticky flag.
// - Events: falling, rising, every 4th or 16th rising edge; new value overwrites.
// - Mode 1010 interrupts only and leaves the pin alone.
// - Mode 1011 sets flag, resets timer to zero next edge, no pin drive.
//
// Added by the designer: the register addresses and register access over APB.
`include "ccu_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ccu_top (
    input  wire logic        CLK_SYS,
    input  wire logic        SYS_RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [15:0] TIMER_A_COUNT,
    input  wire logic [15:0] TIMER_B_COUNT,
    input  wire logic        TIMER_A_EXT_CLK,
    input  wire logic        TIMER_B_EXT_CLK,
    input  wire logic        ENH_PIN_I,
    output logic             ENH_PIN_O,
    output logic             ENH_PIN_OE,
    input  wire logic        STD_PIN_B_I,
    input  wire logic        STD_PIN_C_I,
    output logic             STD_PIN_B_O,
    output logic             STD_PIN_B_OE,
    output logic             STD_PIN_C_O,
    output logic             STD_PIN_C_OE,
    output logic             TIMER_A_RESET,
    output logic             TIMER_B_RESET,
    output logic             TIMER_A_HOLD,
    output logic             TIMER_B_HOLD
);
    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] raw_pins;
    assign raw_pins = {STD_PIN_C_I, STD_PIN_B_I, ENH_PIN_I};

    // Two flops for every pin input
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
        end else begin
            sync1_r <= raw_pins;
            sync2_r <= sync1_r;
        end
    end

    // ************************************************************
    // State and next state
    // ************************************************************
    ccu_pkg::ccu_state_t st_r;
    ccu_pkg::ccu_state_t st_nxt;

    logic        wr_acc;
    logic        rd_acc;
    logic        sel_a;
    logic [15:0] tcount;
    logic        pin_in;
    logic [3:0]  md;
    logic        is_cap;
    logic        evt;
    logic        fire;
    logic        match;
    logic        drives;
    logic        drv_mode;
    logic [3:0]  plast;

    // Next-state logic for bus, captures and compares
    always_comb begin
        st_nxt = st_r;
        wr_acc = PSEL && PENABLE && PWRITE;
        rd_acc = PSEL && PENABLE && !PWRITE;
        sel_a = 1'b0;
        tcount = 16'h0000;
        pin_in = 1'b0;
        md = 4'h0;
        is_cap = 1'b0;
        evt = 1'b0;
        fire = 1'b0;
        match = 1'b0;
        drives = 1'b0;
        drv_mode = 1'b0;
        plast = 4'h0;
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        st_nxt.tmr_rst = 2'h0;
        // Decode at the first access edge; ready, read data and error stand the next cycle
        if (PSEL && PENABLE && !st_r.pready) begin
            st_nxt.pready = 1'b1;
            st_nxt.prdata = 32'h0000_0000;
            unique case (PADDR)
                `CCU_OFF_CTRL1:  st_nxt.prdata[7:0] = st_r.u[0].ctrl;
                `CCU_OFF_CTRL2:  st_nxt.prdata[7:0] = st_r.u[1].ctrl;
                `CCU_OFF_HOLD1H: st_nxt.prdata[7:0] = st_r.u[0].hold[15:8];
                `CCU_OFF_HOLD1L: st_nxt.prdata[7:0] = st_r.u[0].hold[7:0];
                `CCU_OFF_HOLD2H: st_nxt.prdata[7:0] = st_r.u[1].hold[15:8];
                `CCU_OFF_HOLD2L: st_nxt.prdata[7:0] = st_r.u[1].hold[7:0];
                `CCU_OFF_TSEL: begin
                    st_nxt.prdata[`CCU_TSEL_U1_BIT] = st_r.tsel[0];
                    st_nxt.prdata[`CCU_TSEL_U2_BIT] = st_r.tsel[1];
                end
                `CCU_OFF_ROUTE:  st_nxt.prdata[`CCU_ROUTE_BIT] = st_r.route;
                `CCU_OFF_FLAGS:  st_nxt.prdata[1:0] = {st_r.u[1].flag, st_r.u[0].flag};
                `CCU_OFF_PORT:   st_nxt.prdata[1:0] = {st_r.port_dir_out, st_r.port_lat};
                `CCU_OFF_SLEEP:  st_nxt.prdata[0] = st_r.sleep;
                default:         st_nxt.pslverr = 1'b1;
            endcase
            // Writes and refused reads answer with zero data
            if (!rd_acc || st_nxt.pslverr) begin
                st_nxt.prdata = 32'h0000_0000;
            end
        end
        // Writes land at the edge that completes the transfer, while ready stands
        if (wr_acc && st_r.pready) begin
            unique case (PADDR)
                // Direct prescale switches keep the counter
                `CCU_OFF_CTRL1:  st_nxt.u[0].ctrl = PWDATA[7:0];
                `CCU_OFF_CTRL2:  st_nxt.u[1].ctrl = {2'h0, PWDATA[5:0]};
                `CCU_OFF_HOLD1H: st_nxt.u[0].hold[15:8] = PWDATA[7:0];
                `CCU_OFF_HOLD1L: st_nxt.u[0].hold[7:0] = PWDATA[7:0];
                `CCU_OFF_HOLD2H: st_nxt.u[1].hold[15:8] = PWDATA[7:0];
                `CCU_OFF_HOLD2L: st_nxt.u[1].hold[7:0] = PWDATA[7:0];
                `CCU_OFF_TSEL: begin
                    st_nxt.tsel[0] = PWDATA[`CCU_TSEL_U1_BIT];
                    st_nxt.tsel[1] = PWDATA[`CCU_TSEL_U2_BIT];
                end
                `CCU_OFF_ROUTE:  st_nxt.route = PWDATA[`CCU_ROUTE_BIT];
                `CCU_OFF_FLAGS: begin
                    // Write one to clear; hardware set below wins
                    st_nxt.u[0].flag = st_r.u[0].flag & ~PWDATA[0];
                    st_nxt.u[1].flag = st_r.u[1].flag & ~PWDATA[1];
                end
                `CCU_OFF_PORT: begin
                    st_nxt.port_lat = PWDATA[0];
                    st_nxt.port_dir_out = PWDATA[1];
                end
                `CCU_OFF_SLEEP:  st_nxt.sleep = PWDATA[0];
                default:         st_nxt.pslverr = 1'b0; // Refused: no effect
            endcase
        end
        // Sleep holds system-clocked timers; external clocks keep counting
        st_nxt.tmr_hold[0] = st_nxt.sleep && !TIMER_A_EXT_CLK;
        st_nxt.tmr_hold[1] = st_nxt.sleep && !TIMER_B_EXT_CLK;
        // Per-unit capture and compare
        for (int i = 0; i < 2; i++) begin
            md = st_r.u[i].ctrl[3:0];
            sel_a = !st_r.tsel[i];
            tcount = sel_a ? TIMER_A_COUNT : TIMER_B_COUNT;
            // Unit two reads the routed pin; a driven pin reads the port latch
            if (i == 0) begin
                pin_in = sync2_r[0];
            end else begin
                pin_in = st_r.route ? sync2_r[2] : sync2_r[1];
            end
            drives = (i == 0) ? st_r.pin_oe[0] : (st_r.pin_oe[1] || st_r.pin_oe[2]);
            if (drives && st_r.port_dir_out) begin
                pin_in = st_r.port_lat;
            end else if (st_r.port_dir_out && md[3:2] == 2'h1) begin
                pin_in = st_r.port_lat;
            end
            // Edge detector runs in every mode, so a mode change may capture
            st_nxt.u[i].pin_d = pin_in;
            is_cap = (md[3:2] == 2'h1);
            evt = 1'b0;
            fire = 1'b0;
            plast = (md == `CCU_M_CAP_R4) ? `CCU_PRE4_LAST : `CCU_PRE16_LAST;
            if (!is_cap) begin
                st_nxt.u[i].pre = 4'h0;
            end else if (md == `CCU_M_CAP_FALL) begin
                fire = st_r.u[i].pin_d && !pin_in;
            end else begin
                evt = !st_r.u[i].pin_d && pin_in;
                if (md == `CCU_M_CAP_RISE) begin
                    fire = evt;
                end else if (evt) begin
                    // Counted rising edges for 1:4 and 1:16
                    fire = (st_r.u[i].pre[3:0] & plast) == plast;
                    st_nxt.u[i].pre = fire ? 4'h0 : st_r.u[i].pre + 4'h1;
                end
            end
            if (fire) begin
                st_nxt.u[i].hold = tcount;
                st_nxt.u[i].flag = 1'b1;
            end
            // Compare: edge of equality so one match gives one action
            match = (md[3] || md == `CCU_M_TOGGLE) && (tcount == st_r.u[i].hold);
            st_nxt.u[i].match_d = match;
            if (match && !st_r.u[i].match_d) begin
                st_nxt.u[i].flag = 1'b1;
                unique case (md)
                    `CCU_M_TOGGLE:  st_nxt.u[i].outl = !st_r.u[i].outl;
                    `CCU_M_SET:     st_nxt.u[i].outl = 1'b1;
                    `CCU_M_CLR:     st_nxt.u[i].outl = 1'b0;
                    `CCU_M_SPECIAL: st_nxt.tmr_rst[sel_a ? 0 : 1] = 1'b1;
                    default:        st_nxt.u[i].outl = st_r.u[i].outl;
                endcase
            end
            // Cleared control forces the compare latch low
            if (st_r.u[i].ctrl == `CCU_CTRL_RST) begin
                st_nxt.u[i].outl = 1'b0;
            end
            // Pin is driven only in toggle, set and clear modes
            drv_mode = (md == `CCU_M_TOGGLE) || (md == `CCU_M_SET)
                       || (md == `CCU_M_CLR);
            // Unit two drives only the pin that its route selects
            if (i == 0) begin
                st_nxt.pin_oe[0] = drv_mode;
            end else begin
                st_nxt.pin_oe[1] = drv_mode && !st_nxt.route;
                st_nxt.pin_oe[2] = drv_mode && st_nxt.route;
            end
            st_nxt.pin_o[i] = st_nxt.u[i].outl;
        end
    end

    // State register; reset clears prescalers and controls
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_r <= '0;
            st_r.route <= `CCU_ROUTE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Every output comes straight from the state register
    assign PRDATA = st_r.prdata;
    assign PREADY = st_r.pready;
    assign PSLVERR = st_r.pslverr;
    assign ENH_PIN_O = st_r.pin_o[0];
    assign ENH_PIN_OE = st_r.pin_oe[0];
    assign STD_PIN_B_O = st_r.pin_o[1];
    assign STD_PIN_B_OE = st_r.pin_oe[1];
    assign STD_PIN_C_O = st_r.pin_o[1];
    assign STD_PIN_C_OE = st_r.pin_oe[2];
    assign TIMER_A_RESET = st_r.tmr_rst[0];
    assign TIMER_B_RESET = st_r.tmr_rst[1];
    assign TIMER_A_HOLD = st_r.tmr_hold[0];
    assign TIMER_B_HOLD = st_r.tmr_hold[1];

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_cap_flag;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (st_r.u[0].ctrl[3:0] == `CCU_M_CAP_RISE && !st_r.u[0].pin_d && st_nxt.u[0].pin_d
         && !st_r.port_dir_out) |=> st_r.u[0].flag;
    endproperty
    a_cap_flag: assert property (p_cap_flag) else $error("capture did not set flag");
    property p_pre_off;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (st_r.u[1].ctrl[3:2] != 2'h1) |=> (st_r.u[1].pre == 4'h0);
    endproperty
    a_pre_off: assert property (p_pre_off) else $error("prescaler not cleared");
    property p_swint;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (st_r.u[0].ctrl[3:0] == `CCU_M_SWINT) [*2] |-> !ENH_PIN_OE;
    endproperty
    a_swint: assert property (p_swint) else $error("software mode drove pin");
    property p_route;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        !(STD_PIN_B_OE && STD_PIN_C_OE);
    endproperty
    a_route: assert property (p_route) else $error("both routes driven");
    property p_special;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        $rose(TIMER_A_RESET) |-> (st_r.u[0].flag || st_r.u[1].flag) ##1 !TIMER_A_RESET;
    endproperty
    a_special: assert property (p_special) else $error("timer reset without flag");
    property p_set_mode;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (st_r.u[0].ctrl[3:0] == `CCU_M_SET && $rose(st_r.u[0].match_d)) |-> ENH_PIN_O
            && st_r.u[0].flag;
    endproperty
    a_set_mode: assert property (p_set_mode) else $error("set mode missed");
    property p_cmp_flag;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        $rose(st_r.u[0].match_d) |-> st_r.u[0].flag;
    endproperty
    a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag late");
    property p_ready;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (PSEL && !PENABLE) ##1 (PSEL && PENABLE) |=> PREADY;
    endproperty
    a_ready: assert property (p_ready) else $error("bus answer late");
    property p_flag_sticky;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (st_r.u[0].flag && !(wr_acc && PADDR == `CCU_OFF_FLAGS)) |=> st_r.u[0].flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");
    property p_spec_pin;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (st_r.u[0].ctrl[3:0] == `CCU_M_SPECIAL) [*2] |-> !ENH_PIN_OE;
    endproperty
    a_spec_pin: assert property (p_spec_pin) else $error("special mode drove pin");
    property p_toggle;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        ($past(st_r.u[0].ctrl[3:0]) == `CCU_M_TOGGLE && $rose(st_r.u[0].match_d))
            |-> (ENH_PIN_O != $past(ENH_PIN_O));
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle mode missed");
    property p_clr_mode;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        ($past(st_r.u[0].ctrl[3:0]) == `CCU_M_CLR && $rose(st_r.u[0].match_d))
            |-> (!ENH_PIN_O && st_r.u[0].flag);
    endproperty
    a_clr_mode: assert property (p_clr_mode) else $error("clear mode missed");
    property p_cap_hold;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (st_r.u[0].ctrl[3:0] == `CCU_M_CAP_RISE && !st_r.u[0].pin_d && st_nxt.u[0].pin_d
         && !st_r.tsel[0]) |=> (st_r.u[0].hold == $past(TIMER_A_COUNT));
    endproperty
    a_cap_hold: assert property (p_cap_hold) else $error("capture value wrong");
    c_cap: cover property (@(posedge CLK_SYS) $rose(st_r.u[0].flag));
    c_rst: cover property (@(posedge CLK_SYS) TIMER_A_RESET);
    c_tog: cover property (@(posedge CLK_SYS) $changed(ENH_PIN_O));
endmodule
`default_nettype wire

// >>> tb/ccu_far_side.sv
// Far-side model: two 16-bit timers and the three event pins
`timescale 1ns/1ps
`default_nettype none
module ccu_far_side (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        run,
    input  wire logic        load,
    input  wire logic [15:0] load_a,
    input  wire logic [15:0] load_b,
    input  wire logic [1:0]  tmr_rst,
    input  wire logic [1:0]  tmr_hold,
    output logic      [15:0] cnt_a,
    output logic      [15:0] cnt_b,
    input  wire logic [2:0]  lvl,
    input  wire logic [2:0]  oe,
    input  wire logic [2:0]  o,
    output logic      [2:0]  pin
);
    logic [1:0] div_r;

    // Pin wire: the unit's drive while enabled, else the outside level
    assign pin = (oe & o) | (~oe & lvl);

    // Synchronous timers ticking once every four system clocks; run low stalls them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_r <= 2'h0;
            cnt_a <= 16'h0000;
            cnt_b <= 16'h0000;
        end else begin
            div_r <= div_r + 2'h1;
            if (load) begin
                cnt_a <= load_a;
                cnt_b <= load_b;
            end else begin
                if (tmr_rst[0])
                    cnt_a <= 16'h0000;
                else if (run && !tmr_hold[0] && div_r == 2'h3)
                    cnt_a <= cnt_a + 16'h0001;
                if (tmr_rst[1])
                    cnt_b <= 16'h0000;
                else if (run && !tmr_hold[1] && div_r == 2'h3)
                    cnt_b <= cnt_b + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench of the capture/compare block
`timescale 1ns/1ps
`default_nettype none
`include "ccu_regs.svh"
module tb;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        run = 1'b0, load = 1'b0, ext_a = 1'b0, ext_b = 1'b0, pready, pslverr, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] cnt_a, cnt_b, ld_a = 16'h0, ld_b = 16'h0;
    logic [2:0]  lvl = 3'h0, oe, o, pin;
    logic [1:0]  trst, thold;
    int          bad_count = 0, check_count = 0;
    int          cm[5] = '{2, 8, 9, 10, 11};

    // Device under test and its far side
    ccu_top i_dut (.CLK_SYS(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .TIMER_A_COUNT(cnt_a), .TIMER_B_COUNT(cnt_b),
        .TIMER_A_EXT_CLK(ext_a), .TIMER_B_EXT_CLK(ext_b), .ENH_PIN_I(pin[0]),
        .ENH_PIN_O(o[0]), .ENH_PIN_OE(oe[0]), .STD_PIN_B_I(pin[1]), .STD_PIN_C_I(pin[2]),
        .STD_PIN_B_O(o[1]), .STD_PIN_B_OE(oe[1]), .STD_PIN_C_O(o[2]), .STD_PIN_C_OE(oe[2]),
        .TIMER_A_RESET(trst[0]), .TIMER_B_RESET(trst[1]), .TIMER_A_HOLD(thold[0]),
        .TIMER_B_HOLD(thold[1]));
    ccu_far_side i_far (.clk(clk), .rst(rst), .run(run), .load(load), .load_a(ld_a),
        .load_b(ld_b), .tmr_rst(trst), .tmr_hold(thold), .cnt_a(cnt_a), .cnt_b(cnt_b),
        .lvl(lvl), .oe(oe), .o(o), .pin(pin));

    // 20 MHz system clock
    always #25 clk = ~clk;

    // Verdict and end of run
    task automatic tally_and_finish();
        if (bad_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Compare one value and report a mismatch
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            bad_count++;
        end
    endtask

    // One APB transfer; the wait for ready is bounded
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        err = pslverr;
        if (n >= 40)
            bad_count++;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Register read with comparison
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask

    // One pulse on an event pin, long enough for the input synchronisers
    task automatic pulse(input int p, input int m);
        @(posedge clk);
        lvl[p] <= 1'b1;
        repeat (6) @(posedge clk);
        if (m == 4)
            rdc("flag after rise", `CCU_OFF_FLAGS, 32'h0);
        lvl[p] <= 1'b0;
        repeat (6) @(posedge clk);
    endtask

    // Stall both timers at chosen counts
    task automatic freeze(input logic [15:0] a, input logic [15:0] b);
        @(posedge clk);
        run  <= 1'b0;
        load <= 1'b1;
        ld_a <= a;
        ld_b <= b;
        @(posedge clk);
        load <= 1'b0;
    endtask

    // Pin events needed for one capture in a mode
    function automatic int edges(input int m);
        return (m == 6) ? 4 : (m == 7) ? 16 : 1;
    endfunction

    // Capture on one unit from a random time base picked by a random select bit
    task automatic capture(input int u, input int m);
        logic        ts;
        logic [15:0] a, b, v;
        ts = 1'($urandom);
        a = 16'($urandom);
        b = 16'($urandom);
        v = ts ? b : a;
        freeze(a, b);
        apb(1'b1, `CCU_OFF_TSEL, 32'(ts) << (u ? `CCU_TSEL_U2_BIT : `CCU_TSEL_U1_BIT));
        apb(1'b1, 12'(4 * u), 32'(m));
        apb(1'b1, `CCU_OFF_FLAGS, 32'h3);
        repeat (edges(m) - 1) pulse(2 * u, 5);
        rdc("early flag", `CCU_OFF_FLAGS, 32'h0);
        pulse(2 * u, m);
        rdc("capture flag", `CCU_OFF_FLAGS, 32'h1 << u);
        rdc("hold high", `CCU_OFF_HOLD1H + 12'(8 * u), 32'(v >> 8));
        rdc("hold low", `CCU_OFF_HOLD1L + 12'(8 * u), 32'(v & 16'h00FF));
        apb(1'b1, `CCU_OFF_FLAGS, 32'h1 << u);
        rdc("flag cleared", `CCU_OFF_FLAGS, 32'h0);
        apb(1'b1, 12'(4 * u), 32'h0);
    endtask

    // Compare on the enhanced unit against timer A, matching a few ticks after start
    task automatic cmp(input int m);
        logic [15:0] v;
        v = 16'h0010 + 16'($urandom_range(16'hFF00));
        freeze(v - 16'h0003, 16'($urandom));
        apb(1'b1, `CCU_OFF_TSEL, 32'h0);
        apb(1'b1, `CCU_OFF_HOLD1H, 32'(v >> 8));
        apb(1'b1, `CCU_OFF_HOLD1L, 32'(v & 16'h00FF));
        rdc("hold readback", `CCU_OFF_HOLD1L, 32'(v & 16'h00FF));
        apb(1'b1, `CCU_OFF_CTRL1, 32'h0);
        apb(1'b1, `CCU_OFF_CTRL1, 32'(m));
        apb(1'b1, `CCU_OFF_FLAGS, 32'h3);
        run <= 1'b1;
        repeat (24) @(posedge clk);
        run <= 1'b0;
        rdc("match flag", `CCU_OFF_FLAGS, 32'h1);
        chk("pin enable", (m >= 10) ? 32'h0 : 32'h1, 32'(oe[0]));
        if (m < 10)
            chk("pin level", (m == 9) ? 32'h0 : 32'h1, 32'(o[0]));
        chk("timer cleared", (m == 11) ? 32'h1 : 32'h0, 32'(cnt_a < 16'h0010));
        apb(1'b1, `CCU_OFF_CTRL1, 32'h0);
    endtask

    // Main sequence
    initial begin
        void'($urandom(98597));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rdc("ctrl1 reset", `CCU_OFF_CTRL1, 32'h0);
        rdc("ctrl2 reset", `CCU_OFF_CTRL2, 32'h0);
        rdc("route reset", `CCU_OFF_ROUTE, 32'h1);
        rdc("refused data", 12'h02C, 32'h0);
        chk("refused", 32'h1, 32'(err));
        for (int m = 4; m < 8; m++)
            for (int u = 0; u < 2; u++)
                capture(u, m);
        // Prescaler count across mode writes
        apb(1'b1, `CCU_OFF_CTRL1, 32'h6);
        repeat (2) pulse(0, 6);
        apb(1'b1, `CCU_OFF_CTRL1, 32'h0);
        apb(1'b1, `CCU_OFF_CTRL1, 32'h6);
        apb(1'b1, `CCU_OFF_FLAGS, 32'h3);
        repeat (2) pulse(0, 6);
        rdc("count cleared when off", `CCU_OFF_FLAGS, 32'h0);
        apb(1'b1, `CCU_OFF_CTRL1, 32'h7);
        apb(1'b1, `CCU_OFF_FLAGS, 32'h3);
        repeat (14) pulse(0, 7);
        rdc("count kept on switch", `CCU_OFF_FLAGS, 32'h1);
        apb(1'b1, `CCU_OFF_CTRL1, 32'h0);
        // Second unit pin routing
        apb(1'b1, `CCU_OFF_CTRL2, 32'h5);
        apb(1'b1, `CCU_OFF_FLAGS, 32'h3);
        pulse(1, 5);
        rdc("port b unrouted", `CCU_OFF_FLAGS, 32'h0);
        apb(1'b1, `CCU_OFF_ROUTE, 32'h0);
        apb(1'b1, `CCU_OFF_FLAGS, 32'h3);
        pulse(1, 5);
        rdc("port b routed", `CCU_OFF_FLAGS, 32'h2);
        apb(1'b1, `CCU_OFF_ROUTE, 32'h1);
        apb(1'b1, `CCU_OFF_CTRL2, 32'h0);
        // Port write on a pin driven as output acts as an event
        apb(1'b1, `CCU_OFF_PORT, 32'h2);
        apb(1'b1, `CCU_OFF_CTRL1, 32'h5);
        apb(1'b1, `CCU_OFF_FLAGS, 32'h3);
        apb(1'b1, `CCU_OFF_PORT, 32'h3);
        rdc("port write capture", `CCU_OFF_FLAGS, 32'h1);
        apb(1'b1, `CCU_OFF_CTRL1, 32'h0);
        apb(1'b1, `CCU_OFF_PORT, 32'h0);
        foreach (cm[i])
            cmp(cm[i]);
        // Timer hold in sleep
        apb(1'b1, `CCU_OFF_SLEEP, 32'h1);
        ext_b <= 1'b1;
        repeat (2) @(posedge clk);
        chk("hold a", 32'h1, 32'(thold[0]));
        chk("hold b", 32'h0, 32'(thold[1]));
        apb(1'b1, `CCU_OFF_SLEEP, 32'h0);
        @(posedge clk);
        chk("hold after wake", 32'h0, 32'(thold[0]));
        tally_and_finish();
    end

    // Watchdog against a hang
    initial begin
        repeat (30000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
